// [cctx_pkg.sv]
// Purpose: Shared constants for the completion stream transmit block.
// Assumes: Completion descriptor occupies the first three Dwords of a packet.
// Notes: Packet bit positions are counted across the packet from bit 0 of Dword 0; DISCONTINUE_BIT indexes the sideband.

// ****************************************
// Package
// ****************************************
package cctx_pkg;
	localparam int DWORD_W = 32;
	localparam int DESC_DW = 3;
	localparam int HDR_DW = 8;
	localparam int LOG_FIRST_DW = 3;
	localparam int LOG_DW = 5;
	localparam int FIFO_DEPTH = 8;
	localparam int DISCONTINUE_BIT = 0;
	localparam int CID_ENABLE_BIT = 88;
	localparam int FORCE_ECRC_BIT = 95;
	localparam int BUS_LSB = 80;
	localparam int DEV_LSB = 75;
	localparam int FUNC_LSB = 72;
	localparam int STATUS_LSB = 43;
	localparam logic [2:0] STATUS_UR = 3'h1;
	localparam logic [2:0] STATUS_CA = 3'h4;
	localparam logic [3:0] BEAT_RST = 4'h0;
	localparam logic [15:0] CID_RST = 16'h0000;
	typedef enum logic [1:0] {
		CCTX_IDLE = 2'b00,
		CCTX_PKT = 2'b01,
		CCTX_MARK = 2'b10,
		CCTX_FLUSH = 2'b11
	} cctx_state_t;
endpackage

// [cctx_fifo.sv]
// Purpose: Beat buffer between the completion stream and the link side.
// Assumes: DEPTH is a power of two.
// Notes: Ready on the write side falls when full, stalling the source.

// ****************************************
// FIFO
// ****************************************
module cctx_fifo #(
	parameter int W = 64,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Write side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Read side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];

	always_comb begin
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		wr_d = push ? wr_q + AW'(1) : wr_q;
		rd_d = pop ? rd_q + AW'(1) : rd_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - (AW+1)'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
endmodule

// [cctx_tx.sv]
// Purpose: Takes completion packets from user logic and hands beats to the link.
// Assumes: Width and alignment mode are fixed while the port runs.
// Notes: Payload placement is carried through unchanged; the link packs it.

// ****************************************
// Completion transmit
// ****************************************
// Behaviour
// - dword or address aligned, 64/128/256
// - valid drop mid packet nullifies it
// - ready may drop; inputs held
// - discontinue nullifies the packet
// - discontinue error stays sticky
// - discontinue sampled on valid and ready
// - endpoint reports abort as internal error
// - request info goes to header log
// - error completion packed densely
// - bit 88 picks completer id source
// - bit 95 forces digest
module cctx_tx #(
	parameter int DATA_W = 64,
	parameter int SB_W = 33
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Static configuration
	input wire logic is_endpoint_i,
	input wire logic ecrc_enable_i,
	input wire logic [7:0] captured_bus_i,
	input wire logic [4:0] captured_dev_i,
	// Completion stream from user logic
	input wire logic [DATA_W-1:0] completion_stream_data_i,
	input wire logic completion_stream_valid_i,
	input wire logic completion_stream_last_i,
	input wire logic [SB_W-1:0] completion_stream_sideband_i,
	output logic completion_stream_ready_o,
	// Link side beats
	output logic [DATA_W-1:0] link_data_o,
	output logic link_valid_o,
	output logic link_last_o,
	output logic link_nullify_o,
	input wire logic link_ready_i,
	// Per packet attributes
	output logic attr_valid_o,
	output logic [15:0] completer_id_o,
	output logic force_digest_o,
	// Error reporting
	output logic internal_error_o,
	output logic hdr_log_valid_o,
	output logic [cctx_pkg::LOG_DW*cctx_pkg::DWORD_W-1:0] hdr_log_o
);
	localparam int WPB = DATA_W / cctx_pkg::DWORD_W;
	localparam int FW = DATA_W + 2;

	cctx_pkg::cctx_state_t state_q, state_d;
	logic err_q, err_d;
	logic [3:0] beat_q, beat_d;
	logic [31:0] hdr_q [cctx_pkg::HDR_DW];
	logic [31:0] hdr_d [cctx_pkg::HDR_DW];
	logic attr_valid_d, force_digest_d, internal_error_d, hdr_log_valid_d;
	logic [15:0] completer_id_d;
	logic [cctx_pkg::LOG_DW*cctx_pkg::DWORD_W-1:0] hdr_log_d;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
	logic [FW-1:0] fifo_in_data, fifo_out_data;
	logic acc, disc, pkt_err;

	function automatic logic hbit(input logic [31:0] h [cctx_pkg::HDR_DW], input int n);
		return h[n / 32][n % 32];
	endfunction

	function automatic logic [7:0] hbyte(input logic [31:0] h [cctx_pkg::HDR_DW], input int n);
		return h[n / 32][(n % 32) +: 8];
	endfunction

	// ****************************************
	// Ingress control
	// ****************************************
	always_comb begin
		state_d = state_q;
		err_d = err_q;
		beat_d = beat_q;
		hdr_d = hdr_q;
		attr_valid_d = 1'b0;
		completer_id_d = completer_id_o;
		force_digest_d = force_digest_o;
		internal_error_d = 1'b0;
		hdr_log_valid_d = 1'b0;
		hdr_log_d = hdr_log_o;
		fifo_in_valid = 1'b0;
		fifo_in_data = {1'b0, 1'b0, completion_stream_data_i};
		completion_stream_ready_o = fifo_in_ready;
		disc = completion_stream_sideband_i[cctx_pkg::DISCONTINUE_BIT];
		acc = 1'b0;
		pkt_err = err_q;
		case (state_q)
			cctx_pkg::CCTX_IDLE, cctx_pkg::CCTX_PKT: begin
				fifo_in_valid = completion_stream_valid_i;
				acc = completion_stream_valid_i && fifo_in_ready;
				pkt_err = err_q || disc;
				fifo_in_data = {pkt_err, completion_stream_last_i, completion_stream_data_i};
				if (state_q == cctx_pkg::CCTX_PKT && !completion_stream_valid_i) begin
					state_d = cctx_pkg::CCTX_MARK;
					err_d = 1'b1;
				end
			end
			cctx_pkg::CCTX_MARK: begin
				completion_stream_ready_o = 1'b0;
				fifo_in_valid = 1'b1;
				fifo_in_data = {1'b1, 1'b1, {DATA_W{1'b0}}};
				if (fifo_in_ready) begin
					state_d = cctx_pkg::CCTX_FLUSH;
					err_d = 1'b0;
					beat_d = cctx_pkg::BEAT_RST;
					internal_error_d = is_endpoint_i;
				end
			end
			cctx_pkg::CCTX_FLUSH: begin
				completion_stream_ready_o = 1'b1;
				if (completion_stream_valid_i && completion_stream_last_i) begin
					state_d = cctx_pkg::CCTX_IDLE;
				end
			end
			default: begin
				state_d = cctx_pkg::CCTX_IDLE;
			end
		endcase
		if (acc) begin
			for (int i = 0; i < WPB; i++) begin
				if (int'(beat_q) * WPB + i < cctx_pkg::HDR_DW) begin
					hdr_d[int'(beat_q) * WPB + i] = completion_stream_data_i[i*32 +: 32];
				end
			end
			if (int'(beat_q) * WPB < cctx_pkg::DESC_DW &&
				(int'(beat_q) + 1) * WPB >= cctx_pkg::DESC_DW) begin
				attr_valid_d = 1'b1;
				if (hbit(hdr_d, cctx_pkg::CID_ENABLE_BIT)) begin
					completer_id_d = {hbyte(hdr_d, cctx_pkg::BUS_LSB),
						hdr_d[cctx_pkg::FUNC_LSB / 32][(cctx_pkg::FUNC_LSB % 32) +: 8]};
				end else begin
					completer_id_d = {captured_bus_i, captured_dev_i,
						hdr_d[cctx_pkg::FUNC_LSB / 32][(cctx_pkg::FUNC_LSB % 32) +: 3]};
				end
				force_digest_d = ecrc_enable_i || hbit(hdr_d, cctx_pkg::FORCE_ECRC_BIT);
			end
			if (int'(beat_q) * WPB < cctx_pkg::HDR_DW) begin
				beat_d = beat_q + 4'h1;
			end
			err_d = pkt_err;
			state_d = cctx_pkg::CCTX_PKT;
			if (completion_stream_last_i) begin
				state_d = cctx_pkg::CCTX_IDLE;
				err_d = 1'b0;
				beat_d = cctx_pkg::BEAT_RST;
				internal_error_d = pkt_err && is_endpoint_i;
				if ((hdr_d[cctx_pkg::STATUS_LSB / 32][(cctx_pkg::STATUS_LSB % 32) +: 3] ==
					cctx_pkg::STATUS_UR || hdr_d[cctx_pkg::STATUS_LSB / 32]
					[(cctx_pkg::STATUS_LSB % 32) +: 3] == cctx_pkg::STATUS_CA) &&
					int'(beat_q) * WPB + WPB >= cctx_pkg::HDR_DW && !pkt_err) begin
					hdr_log_valid_d = 1'b1;
					for (int j = 0; j < cctx_pkg::LOG_DW; j++) begin
						hdr_log_d[j*32 +: 32] = hdr_d[cctx_pkg::LOG_FIRST_DW + j];
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= cctx_pkg::CCTX_IDLE;
			err_q <= 1'b0;
			beat_q <= cctx_pkg::BEAT_RST;
			attr_valid_o <= 1'b0;
			completer_id_o <= cctx_pkg::CID_RST;
			force_digest_o <= 1'b0;
			internal_error_o <= 1'b0;
			hdr_log_valid_o <= 1'b0;
			hdr_log_o <= '0;
			for (int k = 0; k < cctx_pkg::HDR_DW; k++) begin
				hdr_q[k] <= '0;
			end
		end else begin
			state_q <= state_d;
			err_q <= err_d;
			beat_q <= beat_d;
			attr_valid_o <= attr_valid_d;
			completer_id_o <= completer_id_d;
			force_digest_o <= force_digest_d;
			internal_error_o <= internal_error_d;
			hdr_log_valid_o <= hdr_log_valid_d;
			hdr_log_o <= hdr_log_d;
			hdr_q <= hdr_d;
		end
	end

	// ****************************************
	// Beat buffer and link side
	// ****************************************
	// link stall backs up to user
	cctx_fifo #(
		.W(FW),
		.DEPTH(cctx_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_in_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(link_ready_i),
		.out_data_o(fifo_out_data)
	);

	assign link_valid_o = fifo_out_valid;
	assign link_data_o = fifo_out_data[DATA_W-1:0];
	assign link_last_o = fifo_out_data[DATA_W];
	assign link_nullify_o = fifo_out_data[DATA_W+1] && fifo_out_data[DATA_W];

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_disc_mid;
		acc && disc && !completion_stream_last_i;
	endsequence
	sequence s_drop;
		state_q == cctx_pkg::CCTX_PKT && !completion_stream_valid_i;
	endsequence

	property p_disc_sticky;
		s_disc_mid ##1 (acc [*1]) |-> fifo_in_data[DATA_W+1];
	endproperty
	a_disc_sticky: assert property (p_disc_sticky) else $error("discontinue not sticky");
	property p_drop_mark;
		s_drop |=> state_q == cctx_pkg::CCTX_MARK && !completion_stream_ready_o;
	endproperty
	a_drop_mark: assert property (p_drop_mark) else $error("valid drop not caught");
	property p_mark_null;
		state_q == cctx_pkg::CCTX_MARK && fifo_in_ready |-> fifo_in_valid &&
			fifo_in_data[DATA_W+1:DATA_W] == 2'b11 ##1 state_q == cctx_pkg::CCTX_FLUSH;
	endproperty
	a_mark_null: assert property (p_mark_null) else $error("marker not nullified");
	property p_disc_null;
		acc && disc && completion_stream_last_i |-> fifo_in_data[DATA_W+1:DATA_W] == 2'b11;
	endproperty
	a_disc_null: assert property (p_disc_null) else $error("discontinue not nullified");
	property p_int_err;
		acc && completion_stream_last_i && (err_q || disc) && is_endpoint_i |=> internal_error_o;
	endproperty
	a_int_err: assert property (p_int_err) else $error("abort not reported");
	property p_no_rc_err;
		!is_endpoint_i ##1 !is_endpoint_i |-> !internal_error_o;
	endproperty
	a_no_rc_err: assert property (p_no_rc_err) else $error("root port reported error");
	property p_link_hold;
		link_valid_o && !link_ready_i |=> link_valid_o && $stable(link_data_o) &&
			$stable(link_last_o);
	endproperty
	a_link_hold: assert property (p_link_hold) else $error("link beat lost on stall");
	property p_log_clean;
		hdr_log_valid_o |-> $past(acc) && $past(completion_stream_last_i) && !$past(disc);
	endproperty
	a_log_clean: assert property (p_log_clean) else $error("log without clean end");
	property p_ecrc;
		acc && attr_valid_d && hbit(hdr_d, cctx_pkg::FORCE_ECRC_BIT) |=> force_digest_o;
	endproperty
	a_ecrc: assert property (p_ecrc) else $error("forced digest missed");
endmodule

// [cctx_user_model.sv]
// Purpose: User logic that returns completion packets beat by beat.
// Assumes: A 64-bit stream, so a packet of eight Dwords takes four beats.
// Notes: Data lines that carry no beat show the inverted beat data; last and sideband stay low.

// ****************************************
// User completion source
// ****************************************
module cctx_user_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Command
	input wire logic go_i,
	input wire logic [255:0] pkt_i,
	input wire logic [2:0] disc_beat_i,
	input wire logic drop_i,
	output logic busy_o,
	// Completion stream
	output logic [63:0] data_o,
	output logic valid_o,
	output logic last_o,
	output logic [32:0] sideband_o,
	input wire logic ready_i
);
	logic [1:0] beat_q;
	logic gap_q;
	assign data_o = valid_o ? pkt_i[beat_q*64+:64] : ~pkt_i[beat_q*64+:64];
	assign last_o = valid_o && beat_q == 2'h3;
	assign sideband_o = {32'h0, valid_o && {1'b0, beat_q} == disc_beat_i};
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_o <= 1'b0;
			valid_o <= 1'b0;
			beat_q <= 2'h0;
			gap_q <= 1'b0;
		end else if (!busy_o) begin
			busy_o <= go_i;
			valid_o <= go_i;
			beat_q <= 2'h0;
			gap_q <= 1'b0;
		end else if (!valid_o) begin
			valid_o <= 1'b1;
		end else if (ready_i && beat_q == 2'h3) begin
			busy_o <= 1'b0;
			valid_o <= 1'b0;
		end else if (ready_i) begin
			beat_q <= beat_q + 2'h1;
			valid_o <= !(drop_i && beat_q == 2'h1 && !gap_q);
			gap_q <= gap_q || (drop_i && beat_q == 2'h1);
		end
	end
endmodule

// [completer_completion_stream_tx_bench.sv]
// Purpose: Self-checking bench for the completion transmit block.
// Assumes: 64-bit data path, eight-beat buffer, endpoint and root port configurations.
// Notes: Ordinary packets run from a table; drop and stall cases follow.

// ****************************************
// Bench
// ****************************************
module completer_completion_stream_tx_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [255:0] pkt;
		logic [2:0] disc;
		logic nul;
		logic ierr;
		logic lg;
	} cctx_row_t;
	localparam logic [7:0] CAP_BUS = 8'h5a;
	localparam logic [4:0] CAP_DEV = 5'h0c;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic go = 1'b0;
	logic [255:0] pkt = '0;
	logic [2:0] disc = 3'h7;
	logic drop = 1'b0;
	logic link_rdy = 1'b1;
	logic is_ep = 1'b1;
	logic ecrc_en = 1'b0;
	logic busy, svalid, slast, sready, link_valid_o, link_last_o, link_nullify_o;
	logic attr_valid_o, force_digest_o, internal_error_o, hdr_log_valid_o, fd_q;
	logic [63:0] sdata, link_data_o, first_dat, last_dat;
	logic [32:0] ssb;
	logic [15:0] completer_id_o, cid_q;
	logic [159:0] hdr_log_o, hdr_q;
	logic last_null;
	int pops, ierr_n, log_n, fail_count, total_checks;
	cctx_row_t rows [5];

	always #2 clk_i = ~clk_i;

	cctx_user_model user_u (.clk_i(clk_i), .rstn_i(rstn_i), .go_i(go), .pkt_i(pkt),
		.disc_beat_i(disc), .drop_i(drop), .busy_o(busy), .data_o(sdata),
		.valid_o(svalid), .last_o(slast), .sideband_o(ssb), .ready_i(sready));

	cctx_tx #(.DATA_W(64), .SB_W(33)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
		.is_endpoint_i(is_ep), .ecrc_enable_i(ecrc_en), .captured_bus_i(CAP_BUS),
		.captured_dev_i(CAP_DEV), .completion_stream_data_i(sdata),
		.completion_stream_valid_i(svalid), .completion_stream_last_i(slast),
		.completion_stream_sideband_i(ssb), .completion_stream_ready_o(sready),
		.link_data_o(link_data_o), .link_valid_o(link_valid_o), .link_last_o(link_last_o),
		.link_nullify_o(link_nullify_o), .link_ready_i(link_rdy),
		.attr_valid_o(attr_valid_o), .completer_id_o(completer_id_o),
		.force_digest_o(force_digest_o), .internal_error_o(internal_error_o),
		.hdr_log_valid_o(hdr_log_valid_o), .hdr_log_o(hdr_log_o));

	// Link side and pulse monitor.
	always @(posedge clk_i) begin
		if (link_valid_o && link_rdy) begin
			if (pops == 0) first_dat = link_data_o;
			pops++;
			last_dat = link_data_o;
			if (link_last_o) last_null = link_nullify_o;
		end
		if (attr_valid_o) begin
			cid_q = completer_id_o;
			fd_q = force_digest_o;
		end
		if (hdr_log_valid_o) hdr_q = hdr_log_o;
		ierr_n += internal_error_o;
		log_n += hdr_log_valid_o;
	end

	function automatic logic [255:0] mk(input logic [2:0] st, input logic [31:0] dw2,
		input logic [31:0] s);
		return {s ^ 32'hffff_0000, s + 32'h3, s + 32'h2, s + 32'h1, s, dw2, 18'h0, st,
			11'h004, 32'h0000_0001};
	endfunction

	task automatic check1(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic checkv(input string nm, input logic [159:0] e, input logic [159:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic clear_counts();
		@(negedge clk_i);
		pops = 0;
		ierr_n = 0;
		log_n = 0;
		first_dat = 'x;
		last_dat = 'x;
		last_null = 1'bx;
		cid_q = 'x;
		fd_q = 1'bx;
		hdr_q = 'x;
		@(posedge clk_i);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		@(negedge clk_i);
		while ((busy || (link_valid_o && link_rdy)) && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 200) begin
			fail_count++;
			$display("mismatch wait_idle expected %h seen %h", 1'b0, busy);
		end
		repeat (3) @(posedge clk_i);
	endtask

	task automatic start(input logic [255:0] p, input logic [2:0] d, input logic dr);
		pkt <= p;
		disc <= d;
		drop <= dr;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
	endtask

	task automatic send(input logic [255:0] p, input logic [2:0] d, input logic dr);
		start(p, d, dr);
		wait_idle();
	endtask

	initial begin
		#100000;
		fail_count++;
		finish_test();
	end

	initial begin
		rows[0] = '{mk(3'h0, 32'h0000_0200, 32'h1000_0000), 3'h7, 1'b0, 1'b0, 1'b0};
		rows[1] = '{mk(cctx_pkg::STATUS_UR, 32'h8112_3400, 32'h2000_0000), 3'h7, 1'b0, 1'b0, 1'b1};
		rows[2] = '{mk(cctx_pkg::STATUS_CA, 32'h0000_0500, 32'h3000_0000), 3'h7, 1'b0, 1'b0, 1'b1};
		rows[3] = '{mk(3'h0, 32'h0100_ab00, 32'h4000_0000), 3'h2, 1'b1, 1'b1, 1'b0};
		rows[4] = '{mk(3'h0, 32'h8000_0700, 32'h5000_0000), 3'h3, 1'b1, 1'b1, 1'b0};
		repeat (5) @(negedge clk_i);
		check1("ready_in_reset", 1'b1, sready);
		check1("link_valid_in_reset", 1'b0, link_valid_o);
		repeat (5) @(posedge clk_i);
		rstn_i <= 1'b1;
		foreach (rows[i]) begin
			clear_counts();
			send(rows[i].pkt, rows[i].disc, 1'b0);
			check1("nullify", rows[i].nul, last_null);
			check1("beat_count", 1'b1, pops == 4);
			checkv("first_beat", {96'h0, rows[i].pkt[63:0]}, {96'h0, first_dat});
			check1("internal_error", rows[i].ierr, ierr_n == 1);
			check1("log_pulse", rows[i].lg, log_n == 1);
			if (rows[i].lg) checkv("hdr_log", rows[i].pkt[255:96], hdr_q);
			checkv("completer_id", {144'h0, rows[i].pkt[88] ? rows[i].pkt[87:72] :
				{CAP_BUS, CAP_DEV, rows[i].pkt[74:72]}}, {144'h0, cid_q});
			check1("force_digest", rows[i].pkt[95], fd_q);
		end
		clear_counts();
		send(rows[0].pkt, 3'h7, 1'b1);
		check1("drop_nullify", 1'b1, last_null);
		check1("drop_beats", 1'b1, pops == 3);
		checkv("marker_data", 160'h0, {96'h0, last_dat});
		check1("drop_ierr", 1'b1, ierr_n == 1);
		clear_counts();
		link_rdy <= 1'b0;
		repeat (2) send(rows[1].pkt, 3'h7, 1'b0);
		start(rows[1].pkt, 3'h7, 1'b0);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		check1("full_ready", 1'b0, sready);
		check1("full_held", 1'b1, svalid);
		@(posedge clk_i);
		link_rdy <= 1'b1;
		wait_idle();
		check1("drained_beats", 1'b1, pops == 12);
		checkv("drained_tail", {96'h0, rows[1].pkt[255:192]}, {96'h0, last_dat});
		check1("drained_log", 1'b1, log_n == 3);
		clear_counts();
		start(rows[2].pkt, 3'h7, 1'b0);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		@(negedge clk_i);
		check1("ready_mid_reset", 1'b1, sready);
		check1("link_mid_reset", 1'b0, link_valid_o);
		checkv("cid_mid_reset", 160'h0, {144'h0, completer_id_o});
		@(posedge clk_i);
		rstn_i <= 1'b1;
		clear_counts();
		send(rows[2].pkt, 3'h7, 1'b0);
		check1("after_reset_beats", 1'b1, pops == 4);
		check1("after_reset_log", 1'b1, log_n == 1);
		checkv("after_reset_hdr", rows[2].pkt[255:96], hdr_q);
		is_ep <= 1'b0;
		ecrc_en <= 1'b1;
		clear_counts();
		send(rows[3].pkt, rows[3].disc, 1'b0);
		check1("rp_nullify", 1'b1, last_null);
		check1("rp_no_error", 1'b1, ierr_n == 0);
		check1("digest_enabled", 1'b1, fd_q);
		finish_test();
	end
endmodule
